// ---- pif_clkmon.sv ----
// Clock fail monitor: watches external clock toggles, switches to internal
`timescale 1ns/100ps
`default_nettype none
`include "pif_regs.svh"
module pif_clkmon #(
    parameter int FAIL_CYC = (`PIF_FAIL_TIME_NS + `PIF_CLK_NS - 1) / `PIF_CLK_NS
) (
    input  wire logic clk_i,       // System clock
    input  wire logic rst_i,       // Synchronous reset
    input  wire logic ce_i,        // Clock enable
    input  wire logic ext_mode_i,  // External clock mode selected
    input  wire logic ext_tog_i,   // Synchronised external clock level
    output logic      on_int_o,    // Running on internal oscillator
    output logic      fail_o       // One-cycle pulse on failover
);
    pif_pkg::pif_clk_st_t st_r;
    pif_pkg::pif_clk_st_t st_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        last_r;
    logic        fail_nxt;

    // Count cycles since last external edge; timeout forces internal
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        fail_nxt = 1'b0;
        case (st_r)
            pif_pkg::PIF_CLK_EXT: begin
                if (!ext_mode_i) begin
                    st_nxt = pif_pkg::PIF_CLK_INT;
                end else if (ext_tog_i != last_r) begin
                    cnt_nxt = 16'h0000;
                end else if (cnt_r >= 16'(FAIL_CYC - 1)) begin
                    st_nxt   = pif_pkg::PIF_CLK_HOLD;
                    fail_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            pif_pkg::PIF_CLK_INT: begin
                cnt_nxt = 16'h0000;
                if (ext_mode_i) begin
                    st_nxt = pif_pkg::PIF_CLK_EXT;
                end
            end
            pif_pkg::PIF_CLK_HOLD: begin
                if (!ext_mode_i) begin
                    st_nxt = pif_pkg::PIF_CLK_INT;
                end
            end
            default: st_nxt = pif_pkg::PIF_CLK_INT;
        endcase
    end

    // Register monitor state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r     <= pif_pkg::PIF_CLK_INT;
            cnt_r    <= 16'h0000;
            last_r   <= 1'b0;
            fail_o   <= 1'b0;
            on_int_o <= 1'b1;
        end else if (ce_i) begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            last_r   <= ext_tog_i;
            fail_o   <= fail_nxt;
            on_int_o <= (st_nxt != pif_pkg::PIF_CLK_EXT);
        end
    end

    // Failover always leaves the monitor on the internal oscillator
    chk_fail_on_int: assert property (
        @(posedge clk_i) disable iff (rst_i)
        fail_o |-> on_int_o)
        else $error("failover pulse without internal clock");
endmodule
`default_nettype wire

// ---- pif_flags.sv ----
// Peripheral interrupt flag register with Wishbone slave and port-change flag
`timescale 1ns/100ps
`default_nettype none
`include "pif_regs.svh"
module pif_flags #(
    parameter int FAIL_CYC = (`PIF_FAIL_TIME_NS + `PIF_CLK_NS - 1) / `PIF_CLK_NS,
    parameter int PORT_W   = 8
) (
    input  wire logic              clk_i,         // System clock
    input  wire logic              rst_i,         // Power-on reset, synchronous
    input  wire logic              ce_i,          // Clock enable
    input  wire logic              pin_rst_i,     // External pin or watchdog reset
    input  wire logic              wb_cyc_i,      // Wishbone cycle
    input  wire logic              wb_stb_i,      // Wishbone strobe
    input  wire logic              wb_we_i,       // Wishbone write
    input  wire logic [3:0]        wb_adr_i,      // Wishbone byte address
    input  wire logic [3:0]        wb_sel_i,      // Wishbone byte selects
    input  wire logic [31:0]       wb_dat_i,      // Wishbone write data
    output logic      [31:0]       wb_dat_o,      // Wishbone read data
    output logic                   wb_ack_o,      // Wishbone acknowledge
    input  wire logic              ext_clk_i,     // External oscillator level
    input  wire logic              cmp_a_output,  // Comparator A digital output
    input  wire logic              cmp_b_output,  // Comparator B digital output
    input  wire logic              nv_done_i,     // Nonvolatile write finished pulse
    input  wire logic [PORT_W-1:0] port_pins_i,   // Port pins for change detection
    output logic                   on_int_osc_o,  // System clock on internal oscillator
    output logic                   irq_o          // Level interrupt request
);
    pif_pkg::pif_wb_req_t req;
    logic [7:0]        flags_r, flags_nxt;
    logic [7:0]        mask_r, mask_nxt;
    logic [7:0]        ctrl_r, ctrl_nxt;
    logic [PORT_W-1:0] prev_r, prev_nxt;
    logic              port_flag_r, port_flag_nxt;
    logic              cmpa_r, cmpb_r;
    logic              ack_nxt, irq_nxt;
    logic [31:0]       rd_nxt;
    logic [7:0]        evt;
    logic [7:0]        clr;
    logic [PORT_W+3:0] sync_in, sync_out;
    logic [PORT_W-1:0] pins_s;
    logic              cmpa_s, cmpb_s, ext_s, nv_s, nv_d_r, osc_fail, on_int;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                   sel: wb_sel_i, dat: wb_dat_i[7:0]};

    // Address decode shared by read and write paths
    function automatic logic hit(input pif_pkg::pif_wb_req_t r, input logic [3:0] ofs);
        hit = r.cyc && r.stb && (r.adr == ofs);
    endfunction

    // ==========================================================
    // Input synchronisers
    assign sync_in = {port_pins_i, nv_done_i, ext_clk_i, cmp_b_output, cmp_a_output};
    pif_sync #(.W(PORT_W + 4)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (sync_in),
        .q_o   (sync_out)
    );
    assign {pins_s, nv_s, ext_s, cmpb_s, cmpa_s} = sync_out;

    // ==========================================================
    // Clock monitor
    pif_clkmon #(.FAIL_CYC(FAIL_CYC)) u_mon (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .ext_mode_i (ctrl_r[`PIF_BIT_EXT_MODE]),
        .ext_tog_i  (ext_s),
        .on_int_o   (on_int),
        .fail_o     (osc_fail)
    );

    // Event vector; comparator outputs already high when plus input wins
    always_comb begin
        evt = 8'h00;
        evt[`PIF_BIT_OSC_FAIL] = osc_fail;
        evt[`PIF_BIT_CMP_B]    = cmpb_s ^ cmpb_r;
        evt[`PIF_BIT_CMP_A]    = cmpa_s ^ cmpa_r;
        evt[`PIF_BIT_NV_DONE]  = nv_s & ~nv_d_r;
    end

    // ==========================================================
    // Register next values
    always_comb begin
        clr       = 8'h00;
        mask_nxt  = mask_r;
        ctrl_nxt  = ctrl_r;
        if (hit(req, `PIF_OFS_FLAGS) && req.we && req.sel[0] && !wb_ack_o) begin
            clr = req.dat;
        end
        if (hit(req, `PIF_OFS_MASK) && req.we && req.sel[0] && !wb_ack_o) begin
            mask_nxt = req.dat & `PIF_FLAG_MASK;
        end
        if (hit(req, `PIF_OFS_CTRL) && req.we && req.sel[0] && !wb_ack_o) begin
            ctrl_nxt = req.dat;
        end
        // Set ignores mask and global enable; set beats clear
        flags_nxt = ((flags_r & ~clr) | evt) & `PIF_FLAG_MASK;
        // Previous-value latch reloads only when port is read, never on pin reset
        prev_nxt = prev_r;
        if (hit(req, `PIF_OFS_STATUS) && !req.we && !wb_ack_o) begin
            prev_nxt = pins_s;
        end
        // Port flag cleared by pin reset, set again while mismatch persists
        port_flag_nxt = pin_rst_i ? 1'b0 : (port_flag_r | (pins_s != prev_r));
        if (!pin_rst_i && hit(req, `PIF_OFS_STATUS) && req.we && req.sel[0] && !wb_ack_o
            && req.dat[`PIF_ST_PORTFLAG] && (pins_s == prev_r)) begin
            port_flag_nxt = 1'b0;
        end
        irq_nxt = ctrl_r[`PIF_BIT_GIE] && ((|(flags_r & mask_r)) ||
                  (port_flag_r && ctrl_r[`PIF_BIT_PORT_IE]));
        ack_nxt = req.cyc && req.stb && !wb_ack_o;
        rd_nxt  = 32'h0000_0000;
        case (req.adr)
            `PIF_OFS_FLAGS:  rd_nxt[7:0] = flags_r & `PIF_FLAG_MASK;
            `PIF_OFS_MASK:   rd_nxt[7:0] = mask_r;
            `PIF_OFS_CTRL:   rd_nxt[7:0] = ctrl_r;
            `PIF_OFS_STATUS: rd_nxt[7:0] = {4'h0, cmpb_s, cmpa_s, on_int, port_flag_r};
            default:         rd_nxt      = 32'h0000_0000;
        endcase
    end

    // Register everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r      <= `PIF_RST_FLAGS;
            mask_r       <= `PIF_RST_MASK;
            ctrl_r       <= `PIF_RST_CTRL;
            prev_r       <= '0;
            port_flag_r  <= 1'b0;
            cmpa_r       <= 1'b0;
            cmpb_r       <= 1'b0;
            nv_d_r       <= 1'b0;
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
            irq_o        <= 1'b0;
            on_int_osc_o <= 1'b1;
        end else if (ce_i) begin
            flags_r      <= flags_nxt;
            mask_r       <= mask_nxt;
            ctrl_r       <= ctrl_nxt;
            prev_r       <= prev_nxt;
            port_flag_r  <= port_flag_nxt;
            cmpa_r       <= cmpa_s;
            cmpb_r       <= cmpb_s;
            nv_d_r       <= nv_s;
            wb_ack_o     <= ack_nxt;
            wb_dat_o     <= rd_nxt;
            irq_o        <= irq_nxt;
            on_int_osc_o <= on_int;
        end
    end

    // ==========================================================
    // Checks
    chk_set_beats_clear: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        evt[`PIF_BIT_CMP_A] |=> flags_r[`PIF_BIT_CMP_A])
        else $error("comparator A event lost");
    chk_low_bits_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        flags_r[3:0] == 4'h0)
        else $error("low flag bits not zero");
    chk_osc_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        osc_fail |=> flags_r[`PIF_BIT_OSC_FAIL])
        else $error("oscillator fail flag not set");
    chk_cmp_b_flag: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (cmpb_s != cmpb_r) |=> flags_r[`PIF_BIT_CMP_B])
        else $error("comparator B flag not set");
    chk_nv_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (nv_s && !nv_d_r) |=> flags_r[`PIF_BIT_NV_DONE])
        else $error("write done flag not set");
    chk_flag_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (flags_r[`PIF_BIT_CMP_B] && !clr[`PIF_BIT_CMP_B]) |=> flags_r[`PIF_BIT_CMP_B])
        else $error("flag dropped without clear");
    chk_port_rst_clr: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        pin_rst_i |=> !port_flag_r)
        else $error("port flag not cleared by reset");
    chk_prev_kept: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        pin_rst_i |=> prev_r == $past(prev_r))
        else $error("previous latch changed by pin reset");
    chk_irq_follows: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (ctrl_r[`PIF_BIT_GIE] && |(flags_r & mask_r)) |=> irq_o)
        else $error("unmasked flag did not raise interrupt");

    // Pin reset ends while the pins still differ from the kept latch
    sequence s_pin_rst_mismatch;
        pin_rst_i ##1 (!pin_rst_i && (pins_s != prev_r));
    endsequence

    // Flag comes back right after the reset if the mismatch persists
    chk_port_reflag: assert property (
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        s_pin_rst_mismatch |=> port_flag_r)
        else $error("port flag not set again after pin reset");
endmodule
`default_nettype wire

// ---- pif_pkg.sv ----
// Types shared by the peripheral flag block
`default_nettype none
package pif_pkg;
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [7:0] dat;
    } pif_wb_req_t;

    typedef enum logic [1:0] {
        PIF_CLK_EXT  = 2'b00,
        PIF_CLK_INT  = 2'b01,
        PIF_CLK_HOLD = 2'b10
    } pif_clk_st_t;
endpackage
`default_nettype wire

// ---- pif_regs.svh ----
// Register offsets, field positions, reset values and timing values of the flag block
//
// Overview of operation
// - Flags set on events, ignoring enables
// - Bit 7 sets on oscillator failover
// - Bit 6 sets on comparator B change
// - Bit 5 sets on comparator A change
// - Bit 4 sets on nonvolatile write done
// - Bits 3 to 0 read zero
// - Port flag cleared on reset, resets if mismatch
// - Pin or watchdog reset keeps previous latch
// - Clock monitor detects failure, switches internal
// - Comparator output high when plus exceeds minus
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define PIF_OFS_FLAGS    4'h0
`define PIF_OFS_MASK     4'h4
`define PIF_OFS_CTRL     4'h8
`define PIF_OFS_STATUS   4'hC
`define PIF_ADDR_W       4

// ==========================================================
// Field positions
`define PIF_BIT_OSC_FAIL 7
`define PIF_BIT_CMP_B    6
`define PIF_BIT_CMP_A    5
`define PIF_BIT_NV_DONE  4
`define PIF_FLAG_MASK    8'hF0
`define PIF_BIT_GIE      0
`define PIF_BIT_EXT_MODE 1
`define PIF_BIT_PORT_IE  2
`define PIF_ST_PORTFLAG  0
`define PIF_ST_ON_INT    1
`define PIF_ST_CMP_A     2
`define PIF_ST_CMP_B     3

// ==========================================================
// Reset values
`define PIF_RST_FLAGS    8'h00
`define PIF_RST_MASK     8'h00
`define PIF_RST_CTRL     8'h02

// ==========================================================
// Timing: external clock presumed failed after this long without an edge
`define PIF_FAIL_TIME_NS 2000
`define PIF_CLK_NS       40

`endif

// ---- pif_sync.sv ----
// Two-stage synchroniser for a bus of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module pif_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,  // System clock
    input  wire logic         rst_i,  // Synchronous reset
    input  wire logic         ce_i,   // Clock enable
    input  wire logic [W-1:0] d_i,    // Asynchronous inputs
    output logic      [W-1:0] q_o     // Synchronised outputs
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_nxt;

    // First stage feeds only the second
    always_comb begin
        s1_nxt = ce_i ? d_i : s1_r;
        s2_nxt = ce_i ? s1_r : q_o;
    end

    // Register both stages
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= s1_nxt;
            q_o  <= s2_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- tb_pif_flags.sv ----
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/100ps
`default_nettype none
module tb_pif_flags;
    // ==========================================================
    // Stimulus and observation signals
    logic        clk_i, rst_i, ce_i, pin_rst_i;
    logic        wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, ext_clk_i, cmp_a_output, cmp_b_output, nv_done_i;
    logic [7:0]  port_pins_i;
    logic        on_int_osc_o, irq_o, ext_run;
    logic [31:0] rdata;
    int          failures, cmp_count;

    // ==========================================================
    // Design under test with a short clock-fail count
    pif_flags #(.FAIL_CYC(4), .PORT_W(8)) pif_flags_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pin_rst_i(pin_rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
        .cmp_a_output(cmp_a_output), .cmp_b_output(cmp_b_output),
        .nv_done_i(nv_done_i), .port_pins_i(port_pins_i),
        .on_int_osc_o(on_int_osc_o), .irq_o(irq_o)
    );

    // ==========================================================
    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // External oscillator toggles every third cycle while enabled
    initial begin
        ext_clk_i = 1'b0;
        forever begin
            repeat (3) @(posedge clk_i);
            if (ext_run) begin
                ext_clk_i <= ~ext_clk_i;
            end
        end
    end

    // Watchdog against a hung handshake
    initial begin
        #(40 * 3000);
        failures++;
        give_verdict();
    end

    // ==========================================================
    // Helper tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic single cycle; waits for ack under a bound
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                           input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("MISMATCH t=%0t no acknowledge", $time);
        end
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] adr, input logic [7:0] d);
        wb_xfer(1'b1, adr, 4'hF, d);
    endtask

    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] m, input logic [31:0] e);
        wb_xfer(1'b0, adr, 4'hF, 8'h00);
        check(rdata & m, e);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic give_verdict();
        $display("failures=%0d cmp_count=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        failures = 0; cmp_count = 0; rst_i = 1'b1; ce_i = 1'b1; pin_rst_i = 1'b0;
        wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 4'h0;
        wb_sel_i = 4'h0; wb_dat_i = 32'h00000000; ext_run = 1'b1;
        cmp_a_output = 1'b0; cmp_b_output = 1'b0; nv_done_i = 1'b0; port_pins_i = 8'h00;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and the unused low bits
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000000);
        rd_chk(4'h4, 32'hFFFFFFFF, 32'h00000000);
        rd_chk(4'h8, 32'hFFFFFFFF, 32'h00000002);
        check({31'h00000000, on_int_osc_o}, 32'h00000000);
        // Comparator and write-done events set their flags with all enables off
        cmp_a_output <= 1'b1;
        wait_n(5);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000020);
        cmp_b_output <= 1'b1;
        wait_n(5);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000060);
        nv_done_i <= 1'b1;
        wait_n(5);
        nv_done_i <= 1'b0;
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000070);
        rd_chk(4'hC, 32'h0000000C, 32'h0000000C);
        // Write one to clear, a zero bit leaves its flag alone
        wr(4'h0, 8'h2F);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000050);
        wr(4'h0, 8'hF0);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000000);
        // Falling comparator edge counts as a change too
        cmp_b_output <= 1'b0;
        wait_n(5);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000040);
        wr(4'h0, 8'h40);
        // Set coinciding with a clear of the same flag survives
        @(posedge clk_i);
        cmp_a_output <= 1'b0;
        @(posedge clk_i);
        wr(4'h0, 8'h20);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000020);
        // Clear before enabling, then raise, mask and clear the interrupt
        wr(4'h0, 8'hF0);
        wr(4'h4, 8'h20);
        cmp_a_output <= 1'b1;
        wait_n(5);
        check({31'h00000000, irq_o}, 32'h00000000);
        wr(4'h8, 8'h03);
        wait_n(3);
        check({31'h00000000, irq_o}, 32'h00000001);
        wr(4'h4, 8'h00);
        wait_n(3);
        check({31'h00000000, irq_o}, 32'h00000000);
        wr(4'h4, 8'h20);
        wr(4'h0, 8'h20);
        wait_n(3);
        check({31'h00000000, irq_o}, 32'h00000000);
        // Clock enable low freezes everything; the held change lands afterwards
        ce_i <= 1'b0;
        cmp_a_output <= 1'b0;
        wait_n(6);
        check({31'h00000000, irq_o}, 32'h00000000);
        ce_i <= 1'b1;
        wait_n(6);
        check({31'h00000000, irq_o}, 32'h00000001);
        // Unmapped place reads zero, disabled byte lane is ignored
        rd_chk(4'h2, 32'hFFFFFFFF, 32'h00000000);
        wb_xfer(1'b1, 4'h4, 4'hE, 8'hF0);
        rd_chk(4'h4, 32'hFFFFFFFF, 32'h00000020);
        // Port-change flag: reset clears it, kept latch sets it again
        port_pins_i <= 8'h5A;
        wait_n(5);
        rd_chk(4'hC, 32'h00000001, 32'h00000001);
        wr(4'hC, 8'h01);
        rd_chk(4'hC, 32'h00000001, 32'h00000000);
        port_pins_i <= 8'h5B;
        wait_n(5);
        @(posedge clk_i);
        pin_rst_i <= 1'b1;
        @(posedge clk_i);
        pin_rst_i <= 1'b0;
        wait_n(5);
        rd_chk(4'hC, 32'h00000001, 32'h00000001);
        // Oscillator failure switches to internal and sets bit 7
        rd_chk(4'h0, 32'h00000080, 32'h00000000);
        ext_run <= 1'b0;
        wait_n(30);
        check({31'h00000000, on_int_osc_o}, 32'h00000001);
        rd_chk(4'h0, 32'h00000080, 32'h00000080);
        // Power-on reset in mid-run restores the reset values
        rst_i <= 1'b1;
        ext_run <= 1'b1;
        wait_n(3);
        rst_i <= 1'b0;
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000000);
        rd_chk(4'h8, 32'hFFFFFFFF, 32'h00000002);
        check({31'h00000000, on_int_osc_o}, 32'h00000000);
        give_verdict();
    end
endmodule
`default_nettype wire
